// ---- spi_ctrl.sv ----
// serial peripheral control, configuration and shift engine
`timescale 1ns/1ps
`default_nettype none
module spi_ctrl
	import spi_ctrl_pkg::*;
(
	input wire logic clk, // 50 MHz clock
	input wire logic resetn, // async reset, low
	input wire logic [AW-1:0] addr, // byte address
	input wire logic [DW-1:0] wdata, // write data
	input wire logic wr, // write strobe
	input wire logic rd, // read strobe
	output logic [DW-1:0] rdata, // read data, cycle after rd
	input wire logic idle_req, // chip is in idle
	input wire logic reference_clock, // reference clock pin
	input wire logic sck_in, // serial clock pin in
	output logic sck_out, // serial clock out
	output logic sck_oe, // serial clock drive
	input wire logic sdi_in, // serial data in
	output logic serial_out_pin, // serial data out
	output logic serial_out_oe, // data out drive
	input wire logic select_in, // select pin in
	output logic select_out, // select pin out
	output logic select_oe, // select pin drive
	output logic baud_ref_sel, // baud source is reference
	output logic deep_buffer_mode, // deep buffering on
	output logic rx_valid // pulse: character received
);
	logic [31:0] ctrl_reg, ctrl2_reg, ctrl_next, ctrl2_next;
	logic [31:0] tx_reg, rx_reg, sh_reg, rsh_reg, rsh_next;
	logic tx_full_reg, rx_full_reg, rx_valid_reg;
	logic [3:0] s1_reg, s2_reg;
	logic ref_prev_reg, sck_prev_reg;
	logic [7:0] div_reg;
	logic [6:0] half_reg;
	logic [4:0] fcnt_reg;
	logic [4:0] flim;
	state_t state_reg;
	logic sck_reg, sck_oe_reg, sdo_reg, sdo_oe_reg, sel_reg, sel_oe_reg, pulse_reg;
	logic [31:0] rdata_reg;
	logic [5:0] len;
	logic [31:0] init;
	logic on, run, master, framed, sdir, spol, cpol, cedge, smp_end, aud;
	logic base_tick, tick, ev, lead, chg, sample_phase, selected, sync_seen;
	logic start, last, drives_sync;
	logic sck_s, sdi_s, sel_s, ref_s;

	function automatic logic [31:0] alias_op(input logic [31:0] cur, input logic [31:0] d,
		input logic [1:0] op);
		unique case (op)
			OP_CLR: alias_op = cur & ~d;
			OP_SET: alias_op = cur | d;
			OP_INV: alias_op = cur ^ d;
			default: alias_op = d;
		endcase
	endfunction

	assign on = ctrl_reg[B_ON];
	assign run = on & ~(ctrl_reg[B_IDLE_STOP] & idle_req);
	assign master = ctrl_reg[B_MASTER];
	assign framed = ctrl_reg[B_FRAMED];
	assign sdir = ctrl_reg[B_SYNC_DIR];
	assign spol = ctrl_reg[B_SYNC_POL];
	assign aud = ctrl2_reg[B_AUDIO];
	assign cpol = ctrl_reg[B_CPOL] | aud;
	assign cedge = ctrl_reg[B_CLK_EDGE] & ~framed;
	assign smp_end = ctrl_reg[B_SAMPLE] & master;
	assign sck_s = s2_reg[0];
	assign sdi_s = s2_reg[1] & ~ctrl_reg[B_IN_DIS];
	assign sel_s = s2_reg[2];
	assign ref_s = s2_reg[3];

	// pins from outside pass two flops first
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			// select pin idles high; a low copy after reset would look like a select
			s1_reg <= 4'h4;
			s2_reg <= 4'h4;
			ref_prev_reg <= 1'b0;
			sck_prev_reg <= 1'b0;
		end else begin
			s1_reg <= {reference_clock, select_in, sdi_in, sck_in};
			s2_reg <= s1_reg;
			ref_prev_reg <= ref_s;
			sck_prev_reg <= sck_s;
		end
	end

	// control writes through the alias slots
	always_comb begin
		ctrl_next = alias_op(ctrl_reg, wdata, addr[3:2]) & CTRL_MASK;
		if (on) begin
			ctrl_next = (ctrl_next & ~CTRL_LOCK) | (ctrl_reg & CTRL_LOCK);
		end
		if (!ctrl_reg[B_MASTER]) begin
			ctrl_next[B_SAMPLE] = 1'b0;
		end
		ctrl2_next = alias_op(ctrl2_reg, wdata, addr[3:2]) & CTRL2_MASK;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg <= CTRL_RESET;
			ctrl2_reg <= CTRL2_RESET;
		end else if (wr && addr[7:4] == CTRL_OFS[7:4]) begin
			ctrl_reg <= ctrl_next;
		end else if (wr && addr[7:4] == CTRL2_OFS[7:4] && !on) begin
			ctrl2_reg <= ctrl2_next; // audio settings held while running
		end
	end

	// character length
	always_comb begin
		if (aud) begin
			len = (ctrl_reg[B_W_UP] | ctrl_reg[B_W_LO]) ? LEN32 : LEN16;
		end else if (ctrl_reg[B_W_UP]) begin
			len = LEN32;
		end else if (ctrl_reg[B_W_LO]) begin
			len = LEN16;
		end else begin
			len = LEN8;
		end
		init = tx_reg << (LEN32 - len);
	end

	// characters per sync pulse, less one
	always_comb begin
		unique case (ctrl_reg[B_CNT_HI:B_CNT_LO])
			3'h1: flim = 5'h01;
			3'h2: flim = 5'h03;
			3'h3: flim = 5'h07;
			3'h4: flim = 5'h0F;
			3'h5: flim = 5'h1F;
			default: flim = 5'h00; // reserved codes behave as every character
		endcase
	end

	// baud tick from the selected source
	assign base_tick = ctrl_reg[B_BAUD_SRC] ? (ref_s & ~ref_prev_reg) : 1'b1;
	assign tick = base_tick && div_reg == HALF_DIV - 8'h01;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_reg <= 8'h00;
		end else if (!run || state_reg == ST_IDLE || tick) begin
			div_reg <= 8'h00;
		end else if (base_tick) begin
			div_reg <= div_reg + 8'h01;
		end
	end

	// edge events: own divider in master, pin edges in slave
	assign selected = framed | ~ctrl_reg[B_SEL_EN] | ~sel_s;
	assign sync_seen = sel_s == spol;
	assign ev = run & (master ? tick : ((sck_s ^ sck_prev_reg) & selected));
	assign lead = master ? (sck_reg == cpol) : (sck_prev_reg == cpol);
	assign chg = (cedge ? ~lead : lead) & ~(half_reg == 7'h00 & ~cedge);
	assign sample_phase = smp_end ? (cedge ? ~lead : lead) : (cedge ? lead : ~lead);
	assign last = ev && half_reg == {len, 1'b0} - 7'h01;
	assign drives_sync = framed & ~sdir & master;
	always_comb begin
		start = 1'b0;
		if (run && tx_full_reg && state_reg == ST_IDLE) begin
			if (framed && sdir) begin
				start = sync_seen;
			end else begin
				start = master | selected;
			end
		end
	end

	always_comb begin
		rsh_next = rsh_reg;
		if (ev && sample_phase && state_reg == ST_SHIFT) begin
			rsh_next = {rsh_reg[30:0], sdi_s};
		end
	end

	// shift engine
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_IDLE;
			half_reg <= 7'h00;
			sh_reg <= 32'h0000_0000;
			rsh_reg <= 32'h0000_0000;
			sdo_reg <= 1'b0;
		end else if (!on) begin
			state_reg <= ST_IDLE;
			half_reg <= 7'h00;
		end else begin
			rsh_reg <= rsh_next;
			unique case (state_reg)
				ST_IDLE: begin
					if (start) begin
						sh_reg <= {init[30:0], 1'b0};
						sdo_reg <= init[31];
						half_reg <= 7'h00;
						rsh_reg <= 32'h0000_0000;
						if (drives_sync && fcnt_reg == 5'h00 && !ctrl_reg[B_SYNC_EDGE]) begin
							state_reg <= ST_LEAD;
						end else begin
							state_reg <= ST_SHIFT;
						end
					end
				end
				ST_LEAD: begin
					if (ev) begin
						half_reg <= half_reg + 7'h01;
						if (half_reg == 7'h01) begin
							half_reg <= 7'h00;
							state_reg <= ST_SHIFT;
						end
					end
				end
				ST_SHIFT: begin
					if (ev) begin
						half_reg <= half_reg + 7'h01;
						if (chg) begin
							sdo_reg <= sh_reg[31];
							sh_reg <= {sh_reg[30:0], 1'b0};
						end
						if (last) begin
							state_reg <= ST_END;
						end
					end
				end
				ST_END: begin
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// data register and receive holding
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_reg <= 32'h0000_0000;
			tx_full_reg <= 1'b0;
		end else if (wr && addr == DATA_OFS) begin
			tx_reg <= wdata;
			tx_full_reg <= 1'b1;
		end else if (start) begin
			tx_full_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_reg <= 32'h0000_0000;
			rx_full_reg <= 1'b0;
			rx_valid_reg <= 1'b0;
		end else begin
			rx_valid_reg <= state_reg == ST_END;
			if (state_reg == ST_END) begin
				rx_reg <= rsh_reg;
				rx_full_reg <= 1'b1; // a new character beats a same-cycle read
			end else if (rd && addr == DATA_OFS) begin
				rx_full_reg <= 1'b0;
			end
		end
	end

	// characters since the last sync pulse
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			fcnt_reg <= 5'h00;
		end else if (!framed) begin
			fcnt_reg <= 5'h00;
		end else if (state_reg == ST_END) begin
			fcnt_reg <= (fcnt_reg >= flim) ? 5'h00 : fcnt_reg + 5'h01;
		end
	end

	// frame sync pulse, active while pulse_reg is high
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pulse_reg <= 1'b0;
		end else if (!on || state_reg == ST_END) begin
			pulse_reg <= 1'b0;
		end else if (start) begin
			pulse_reg <= drives_sync && fcnt_reg == 5'h00;
		end else if (!ctrl_reg[B_SYNC_PW] && ev && half_reg == 7'h01) begin
			pulse_reg <= 1'b0;
		end
	end

	// pins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sck_reg <= 1'b0;
			sel_reg <= 1'b1;
			sel_oe_reg <= 1'b0;
			sdo_oe_reg <= 1'b0;
			sck_oe_reg <= 1'b0;
		end else begin
			if (master && ev && (state_reg == ST_LEAD || state_reg == ST_SHIFT)) begin
				sck_reg <= ~sck_reg;
			end else if (state_reg == ST_IDLE || state_reg == ST_END) begin
				sck_reg <= cpol;
			end
			sdo_oe_reg <= on & ~ctrl_reg[B_OUT_DIS];
			// registered so the drive cannot glitch when idle_req moves
			sck_oe_reg <= on & ~ctrl_reg[B_OUT_DIS] & master & run;
			sel_oe_reg <= on & master & (drives_sync | (~framed & ctrl_reg[B_AUTO_SEL]));
			if (framed) begin
				sel_reg <= pulse_reg ? spol : ~spol;
			end else begin
				sel_reg <= (state_reg == ST_LEAD || state_reg == ST_SHIFT) ? spol : ~spol;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_reg <= 32'h0000_0000;
		end else if (rd) begin
			unique case (addr)
				CTRL_OFS: rdata_reg <= ctrl_reg;
				CTRL2_OFS: rdata_reg <= ctrl2_reg;
				DATA_OFS: rdata_reg <= rx_reg;
				STAT_OFS: begin
					rdata_reg <= 32'h0000_0000;
					rdata_reg[S_RXFULL] <= rx_full_reg;
					rdata_reg[S_TXFULL] <= tx_full_reg;
					rdata_reg[S_BUSY] <= state_reg != ST_IDLE;
					rdata_reg[S_FCNT +: 5] <= fcnt_reg;
				end
				default: rdata_reg <= 32'h0000_0000;
			endcase
		end else begin
			rdata_reg <= 32'h0000_0000;
		end
	end

	assign rdata = rdata_reg;
	assign sck_out = sck_reg;
	assign sck_oe = sck_oe_reg;
	assign serial_out_pin = sdo_reg;
	assign serial_out_oe = sdo_oe_reg;
	assign select_out = sel_reg;
	assign select_oe = sel_oe_reg;
	assign baud_ref_sel = ctrl_reg[B_BAUD_SRC];
	assign deep_buffer_mode = ctrl_reg[B_DEEP_BUF];
	assign rx_valid = rx_valid_reg;
endmodule // spi_ctrl
`default_nettype wire

// ---- spi_ctrl_pkg.sv ----
// constants shared by the serial control block
package spi_ctrl_pkg;
	localparam int DW = 32;
	localparam int AW = 8;
	// byte addresses; control words take four slots: write, clear, set, invert
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] CTRL2_OFS = 8'h10;
	localparam logic [7:0] DATA_OFS = 8'h20;
	localparam logic [7:0] STAT_OFS = 8'h30;
	localparam logic [1:0] OP_WRITE = 2'h0;
	localparam logic [1:0] OP_CLR = 2'h1;
	localparam logic [1:0] OP_SET = 2'h2;
	localparam logic [1:0] OP_INV = 2'h3;
	// serial_control field positions
	localparam int B_FRAMED = 31;
	localparam int B_SYNC_DIR = 30;
	localparam int B_SYNC_POL = 29;
	localparam int B_AUTO_SEL = 28;
	localparam int B_SYNC_PW = 27;
	localparam int B_CNT_HI = 26;
	localparam int B_CNT_LO = 24;
	localparam int B_BAUD_SRC = 23;
	localparam int B_SYNC_EDGE = 17;
	localparam int B_DEEP_BUF = 16;
	localparam int B_ON = 15;
	localparam int B_IDLE_STOP = 13;
	localparam int B_OUT_DIS = 12;
	localparam int B_W_UP = 11;
	localparam int B_W_LO = 10;
	localparam int B_SAMPLE = 9;
	localparam int B_CLK_EDGE = 8;
	localparam int B_SEL_EN = 7;
	localparam int B_CPOL = 6;
	localparam int B_MASTER = 5;
	localparam int B_IN_DIS = 4;
	// second control word
	localparam int B_AUDIO = 7;
	localparam logic [31:0] CTRL_MASK = 32'hFF83_BFFF;
	localparam logic [31:0] CTRL2_MASK = 32'h0000_9F8B;
	localparam logic [31:0] CTRL_LOCK = 32'h0081_0000;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL2_RESET = 32'h0000_0000;
	// status bit positions
	localparam int S_RXFULL = 0;
	localparam int S_TXFULL = 1;
	localparam int S_BUSY = 2;
	localparam int S_FCNT = 8;
	// character lengths in bits
	localparam logic [5:0] LEN8 = 6'h08;
	localparam logic [5:0] LEN16 = 6'h10;
	localparam logic [5:0] LEN32 = 6'h20;
	// half bit period in source ticks
	localparam logic [7:0] HALF_DIV = 8'h04;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_LEAD = 4'b0010,
		ST_SHIFT = 4'b0100,
		ST_END = 4'b1000
	} state_t;
endpackage

// ---- spi_ctrl_sva.sv ----
// port-level assertions for the serial control block
`timescale 1ns/1ps
`default_nettype none
module spi_ctrl_sva
	import spi_ctrl_pkg::*;
(
	input wire logic clk, // clock
	input wire logic resetn, // reset
	input wire logic [AW-1:0] addr, // address
	input wire logic [DW-1:0] wdata, // data
	input wire logic wr, // write
	input wire logic rd, // read
	input wire logic [DW-1:0] rdata, // read data
	input wire logic idle_req, // chip idle
	input wire logic sck_out, // clock
	input wire logic sck_oe, // clock drive
	input wire logic serial_out_oe, // data drive
	input wire logic select_oe, // select drive
	input wire logic baud_ref_sel, // source
	input wire logic deep_buffer_mode, // buffering
	input wire logic rx_valid // received
);
	logic [31:0] c_reg, c2_reg, c_next;
	logic oe_ok, sel_ok, lvl, frz;
	function automatic logic [31:0] alias_op(input logic [31:0] o, d, input logic [1:0] op);
		case (op)
			OP_CLR: return o & ~d;
			OP_SET: return o | d;
			OP_INV: return o ^ d;
			default: return d;
		endcase
	endfunction
	// shadow of both control words so outputs can be tied to what software wrote
	always_comb begin
		c_next = alias_op(c_reg, wdata, addr[3:2]) & CTRL_MASK;
		if (c_reg[B_ON]) c_next = (c_next & ~CTRL_LOCK) | (c_reg & CTRL_LOCK);
		if (!c_reg[B_MASTER]) c_next[B_SAMPLE] = 1'b0;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			c_reg <= CTRL_RESET;
			c2_reg <= CTRL2_RESET;
		end else if (wr && addr[7:4] == 4'h0) begin
			c_reg <= c_next;
		end else if (wr && addr[7:4] == 4'h1 && !c_reg[B_ON]) begin
			c2_reg <= alias_op(c2_reg, wdata, addr[3:2]) & CTRL2_MASK;
		end
	end
	assign oe_ok = c_reg[B_ON] & ~c_reg[B_OUT_DIS];
	assign sel_ok = c_reg[B_ON] & c_reg[B_MASTER] & (c_reg[B_FRAMED] ? ~c_reg[B_SYNC_DIR] : c_reg[B_AUTO_SEL]);
	assign lvl = c_reg[B_CPOL] | c2_reg[B_AUDIO];
	assign frz = c_reg[B_ON] & c_reg[B_IDLE_STOP] & idle_req;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	property p_rd_ctrl; rd && addr == CTRL_OFS |=> rdata == c_reg; endproperty
	a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback wrong");
	property p_no_rd; !rd |=> rdata == 32'h0; endproperty
	a_no_rd: assert property (p_no_rd) else $error("read data outside its cycle");
	property p_src; baud_ref_sel == c_reg[B_BAUD_SRC] && deep_buffer_mode == c_reg[B_DEEP_BUF]; endproperty
	a_src: assert property (p_src) else $error("source or buffer flag wrong");
	property p_oe; $stable(oe_ok) |-> serial_out_oe == oe_ok; endproperty
	a_oe: assert property (p_oe) else $error("data out drive wrong");
	property p_sel; $stable(sel_ok) |-> select_oe == sel_ok; endproperty
	a_sel: assert property (p_sel) else $error("select drive wrong");
	property p_lvl; !c_reg[B_ON] && !$past(c_reg[B_ON]) && $stable(lvl) |-> sck_out == lvl; endproperty
	a_lvl: assert property (p_lvl) else $error("clock idle level wrong");
	property p_sck_oe; !$past(c_reg[B_ON] && c_reg[B_MASTER]) |-> !sck_oe; endproperty
	a_sck_oe: assert property (p_sck_oe) else $error("clock driven when not master");
	property p_frz; frz && $past(frz) |-> $stable(sck_out); endproperty
	a_frz: assert property (p_frz) else $error("clock moved in idle stop");
	property p_rxv; rx_valid |=> !rx_valid; endproperty
	a_rxv: assert property (p_rxv) else $error("receive pulse too long");
	c_rx: cover property (rx_valid);
	c_frz: cover property (frz && $past(frz));
	c_sel: cover property (select_oe && c_reg[B_FRAMED]);
endmodule // spi_ctrl_sva
bind spi_ctrl spi_ctrl_sva chk_u (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .idle_req, .sck_out,
	.sck_oe, .serial_out_oe, .select_oe, .baud_ref_sel, .deep_buffer_mode, .rx_valid);
`default_nettype wire

// ---- spi_link_partner.sv ----
// far-side serial device: loops data back and counts clock transitions
`timescale 1ns/1ps
`default_nettype none
module spi_link_partner (
	input wire logic clk, // clock
	input wire logic resetn, // reset
	input wire logic sck_out, // serial clock
	input wire logic serial_out_pin, // data in
	input wire logic serial_out_oe, // data drive
	output logic sdi_in, // data out
	output logic sck_in, // slave clock, still
	output logic select_in, // select, inactive
	output int edges // clock transitions
);
	logic last_q, sck_q;
	// a released line shows the inverse, never a stale copy
	assign sdi_in = serial_out_oe ? serial_out_pin : ~last_q;
	assign sck_in = 1'b0;
	assign select_in = 1'b1;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			last_q <= 1'b0;
			sck_q <= 1'b0;
			edges <= 0;
		end else begin
			last_q <= sdi_in;
			sck_q <= sck_out;
			if (sck_out != sck_q) edges <= edges + 1;
		end
	end
endmodule // spi_link_partner
`default_nettype wire

// ---- spi_control_configuration_bench.sv ----
// self-checking bench for the serial control block
`timescale 1ns/1ps
`default_nettype none
module spi_control_configuration_bench;
	import spi_ctrl_pkg::*;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [7:0] ra; logic [31:0] e;} step_t;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic idle_req = 1'b0;
	logic reference_clock = 1'b0;
	logic [AW-1:0] addr = '0;
	logic [DW-1:0] wdata = '0;
	logic [DW-1:0] rdata, rv;
	logic sck_out, sck_oe, sck_in, sdi_in, serial_out_pin, serial_out_oe;
	logic select_in, select_out, select_oe, baud_ref_sel, deep_buffer_mode, rx_valid;
	int edges, cyc = 0, num_errors = 0, num_checks = 0;
	step_t st[17] = '{
		'{8'h00, 32'h00001040, 8'h00, 32'h00001040}, '{8'h08, 32'h00000C00, 8'h00, 32'h00001C40},
		'{8'h04, 32'h00001000, 8'h00, 32'h00000C40}, '{8'h0C, 32'h00000440, 8'h00, 32'h00000800},
		'{8'h40, 32'hFFFFFFFF, 8'h40, 32'h00000000}, '{8'h00, 32'hFFFFFFFF, 8'h00, 32'hFF83BDFF},
		'{8'h04, 32'h00008000, 8'h00, 32'hFF833DFF}, '{8'h00, 32'h00000000, 8'h00, 32'h00000000},
		'{8'h00, 32'h00810000, 8'h00, 32'h00810000}, '{8'h08, 32'h00008000, 8'h00, 32'h00818000},
		'{8'h00, 32'h00008000, 8'h00, 32'h00818000}, '{8'h10, 32'h00000080, 8'h10, 32'h00000000},
		'{8'h04, 32'h00008000, 8'h00, 32'h00810000}, '{8'h18, 32'h00000080, 8'h10, 32'h00000080},
		'{8'h14, 32'h00000080, 8'h10, 32'h00000000}, '{8'h00, 32'h00000220, 8'h00, 32'h00000020},
		'{8'h00, 32'h00000220, 8'h00, 32'h00000220}};
	spi_ctrl dut_u (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .idle_req, .reference_clock, .sck_in,
		.sck_out, .sck_oe, .sdi_in, .serial_out_pin, .serial_out_oe, .select_in, .select_out, .select_oe,
		.baud_ref_sel, .deep_buffer_mode, .rx_valid);
	spi_link_partner far_u (.clk, .resetn, .sck_out, .serial_out_pin, .serial_out_oe, .sdi_in, .sck_in,
		.select_in, .edges);
	always #10 clk = ~clk;
	always @(posedge clk) reference_clock <= ~reference_clock;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			print_verdict();
		end
	end
	task automatic print_verdict;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	// aliases, reserved bits, locks, unmapped place and sample phase ordering
	task automatic t_regs;
		chk(baud_ref_sel, 1'b0);
		foreach (st[i]) begin
			wreg(st[i].a, st[i].d);
			rreg(st[i].ra, rv);
			chk(rv, st[i].e);
			if (i == 9) chk({baud_ref_sel, deep_buffer_mode}, 2'h3);
		end
	endtask
	// one character through the loopback partner; sc also judges the select pin
	task automatic xfer(input logic [31:0] cfg, d, input int len, input bit sc);
		int e0, n, act;
		logic [31:0] m;
		m = (len == 32) ? 32'hFFFFFFFF : (32'h1 << len) - 32'h1;
		wreg(CTRL_OFS, cfg | 32'h00008020);
		act = 0;
		wreg(DATA_OFS, d);
		e0 = edges; // the idle-level change after the control write is no data edge
		if (cfg[B_IDLE_STOP]) begin
			idle_req <= 1'b1;
			repeat (30) @(posedge clk);
			idle_req <= 1'b0;
		end
		n = 0;
		while (rx_valid !== 1'b1 && n < 3000) begin
			@(posedge clk);
			n++;
			if (select_out === cfg[B_SYNC_POL]) act++;
		end
		chk(n < 3000, 1'b1);
		chk(edges - e0, 2 * len + ((cfg[B_FRAMED] && !cfg[B_SYNC_DIR] && !cfg[B_SYNC_EDGE]) ? 2 : 0));
		rreg(DATA_OFS, rv);
		chk(rv, d & m);
		if (sc) begin
			chk(select_oe, 1'b1);
			chk(act != 0, 1'b1);
			chk(select_out, !cfg[B_SYNC_POL]);
		end
	endtask
	task automatic t_widths;
		xfer(32'h00000000, 32'h000000A5, 8, 1'b0);
		xfer(32'h00000400, 32'h0000C3A5, 16, 1'b0);
		xfer(32'h00000800, 32'h8001F00D, 32, 1'b0);
		xfer(32'h00000C00, 32'h12345678, 32, 1'b0);
		xfer(32'h00002140, 32'h0000005A, 8, 1'b0);
	endtask
	task automatic t_framed;
		xfer(32'hA0000000, 32'h00000096, 8, 1'b1);
		xfer(32'h88000000, 32'h00000069, 8, 1'b1);
		xfer(32'h30000000, 32'h0000003C, 8, 1'b1);
	endtask
	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_widths();
		t_framed();
		print_verdict();
	end
endmodule // spi_control_configuration_bench
`default_nettype wire
